// file: hdl/lineif_pkg.sv
package lineif_pkg;
  // global register offsets
  localparam logic [5:0] ADDR_REV   = 6'h00;
  localparam logic [5:0] ADDR_SRST  = 6'h01;
  localparam logic [5:0] ADDR_GCFG  = 6'h20;
  localparam logic [5:0] ADDR_CHREQ = 6'h21;
  // channel-local offsets, address bit 5 picks the channel
  localparam int         CH_SEL_BIT   = 5;
  localparam logic [4:0] OFS_LOCAL_LO = 5'h02;
  localparam logic [4:0] OFS_EN_A     = 5'h13;
  localparam logic [4:0] OFS_EN_B     = 5'h14;
  localparam logic [4:0] OFS_EDGE     = 5'h15;
  localparam logic [4:0] OFS_STATE_A  = 5'h16;
  localparam logic [4:0] OFS_LATCH_A  = 5'h18;
  localparam logic [4:0] OFS_LATCH_B  = 5'h19;
  // global_config fields
  localparam int GC_MON_HI = 7;
  localparam int GC_MON_LO = 6;
  localparam int GC_STD    = 4;
  localparam int GC_BCAST  = 3;
  localparam int GC_GDIS   = 2;
  localparam int GC_PIN_HI = 1;
  localparam int GC_PIN_LO = 0;
  localparam logic [7:0] GCFG_RST  = 8'h00;
  localparam logic [7:0] GCFG_MASK = 8'hdf;
  // request pin modes
  localparam logic [1:0] PIN_OD_LOW = 2'b00;
  localparam logic [1:0] PIN_PP_LOW = 2'b01;
  localparam logic [1:0] PIN_PP_HI  = 2'b10;
  // host bus straps
  localparam logic [1:0] BUS_SERIAL = 2'b01;
  localparam logic [1:0] BUS_PAR_A  = 2'b10;
  localparam logic [1:0] BUS_PAR_B  = 2'b11;
  // per-channel reset values
  localparam logic [7:0] EN_RST   = 8'hff;
  localparam logic [7:0] EDGE_RST = 8'h00;
  // arbitrary value
  localparam logic [7:0] REV_CODE = 8'h5a;
  // serial word layout
  localparam logic [4:0] SER_CMD_BITS  = 5'd8;
  localparam logic [4:0] SER_WORD_BITS = 5'd16;
  localparam int         SER_RW_POS    = 6;
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SRST_TIME_NS  = 1000;
  localparam int SRST_CYCLES   = SRST_TIME_NS / CLK_PERIOD_NS;
  localparam logic [3:0] SRST_HOLD = 4'(SRST_CYCLES - 1);
  localparam int HW_RST_MIN_NS = 100;
  localparam int HW_RST_CYCLES =
    (HW_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// file: hdl/host_serial_port.sv
`timescale 1ns/1ns
`default_nettype none
module host_serial_port
  import lineif_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_clk_en,
  input  wire logic       i_sclk,
  input  wire logic       i_cs_n,
  input  wire logic       i_sdi,
  input  wire logic [7:0] i_rdata,
  output logic            o_rd_req,
  output logic            o_wr_req,
  output logic      [5:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_sdo,
  output logic            o_sdo_oe
);
  typedef struct packed {
    logic        sclk_q;
    logic [4:0]  cnt;
    logic [15:0] bits;
    logic        serial_out_pin;
    logic        sdo_oe;
  } ser_s;

  ser_s s;
  ser_s next_s;
  logic rise;
  logic fall;
  logic rw;

  assign rise     = i_sclk && !s.sclk_q;
  assign fall     = !i_sclk && s.sclk_q;
  assign rw       = s.bits[SER_RW_POS];
  // command byte: address lsb first, then direction bit
  assign o_rd_req = !i_cs_n && rise && rw &&
                    s.cnt == SER_CMD_BITS - 5'd1;
  assign o_wr_req = !i_cs_n && rise && !rw &&
                    s.cnt == SER_WORD_BITS - 5'd1;
  assign o_addr   = s.bits[5:0];
  assign o_wdata  = {i_sdi, s.bits[14:8]};
  assign o_sdo    = s.serial_out_pin;
  assign o_sdo_oe = s.sdo_oe;

  always_comb begin
    next_s = s;
    next_s.sclk_q = i_sclk;
    if (i_cs_n) begin
      next_s.cnt = 5'd0;
      next_s.sdo_oe = 1'b0;
    end else begin
      if (rise && s.cnt < SER_WORD_BITS) begin
        // sample on rising edge
        if (!(rw && s.cnt >= SER_CMD_BITS)) begin
          next_s.bits[s.cnt[3:0]] = i_sdi;
        end
        next_s.cnt = 5'(s.cnt + 5'd1);
      end
      if (o_rd_req) begin
        next_s.bits[15:8] = i_rdata;
      end
      // read data out on falling edge
      if (fall && rw && s.cnt >= SER_CMD_BITS &&
          s.cnt < SER_WORD_BITS) begin
        next_s.serial_out_pin = s.bits[s.cnt[3:0]];
        next_s.sdo_oe = 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s <= '0;
    end else if (i_clk_en) begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// file: hdl/channel_events.sv
`timescale 1ns/1ns
`default_nettype none
module channel_events
  import lineif_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_clk_en,
  input  wire logic [7:0] i_line_state,
  input  wire logic [7:0] i_event_pulse,
  input  wire logic       i_wr,
  input  wire logic [4:0] i_off,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_rd_latch_a,
  input  wire logic       i_rd_latch_b,
  output logic      [7:0] o_latch_a,
  output logic      [7:0] o_latch_b,
  output logic      [7:0] o_en_a,
  output logic      [7:0] o_en_b,
  output logic      [7:0] o_edge,
  output logic      [7:0] o_state,
  output logic            o_pending
);
  typedef struct packed {
    logic [7:0] state;
    logic [7:0] latch_a;
    logic [7:0] latch_b;
    logic [7:0] en_a;
    logic [7:0] en_b;
    logic [7:0] edge_sel;
  } chan_s;

  localparam chan_s CHAN_RST = '{en_a: EN_RST, en_b: EN_RST,
                                 edge_sel: EDGE_RST, default: '0};

  chan_s      s;
  chan_s      next_s;
  logic [7:0] set_a;

  // edge select picks rising (0) or falling (1) transition
  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_edge
      assign set_a[b] = s.edge_sel[b] ?
                        (s.state[b] && !i_line_state[b]) :
                        (!s.state[b] && i_line_state[b]);
    end
  endgenerate

  always_comb begin
    next_s = s;
    next_s.state = i_line_state;
    // set wins over clear-on-read
    next_s.latch_a = set_a | (s.latch_a & {8{!i_rd_latch_a}});
    next_s.latch_b = i_event_pulse |
                     (s.latch_b & {8{!i_rd_latch_b}});
    if (i_wr) begin
      unique case (i_off)
        OFS_EN_A: next_s.en_a = i_wdata;
        OFS_EN_B: next_s.en_b = i_wdata;
        OFS_EDGE: next_s.edge_sel = i_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s <= CHAN_RST;
    end else if (i_clk_en) begin
      s <= next_s;
    end
  end

  assign o_latch_a = s.latch_a;
  assign o_latch_b = s.latch_b;
  assign o_en_a    = s.en_a;
  assign o_en_b    = s.en_b;
  assign o_edge    = s.edge_sel;
  assign o_state   = s.state;
  // enable bit 0 lets a latched event request service
  assign o_pending = |(s.latch_a & ~s.en_a) | |(s.latch_b & ~s.en_b);
endmodule
`default_nettype wire

// file: hdl/host_irq_unit.sv
// Notes on behaviour
// - Host select straps 10: parallel bus, strobe plus direction style.
// - Host select straps 11: parallel bus, separate read and write strobes.
// - Host select straps 01: all register access over the serial port.
// - Serial word: command byte of six address bits and direction, then data.
// - Direction 1 drives read data out serially; 0 takes write data in.
// - All events of both channels share one request pin.
// - Pin config 00: open-drain active-low request.
// - Pin config 01 push-pull active low; 10 push-pull active high.
// - Global disable high suppresses the request pin entirely.
// - Each event latches in its own bit, enabled by its own bit.
// - Enable bit 0 passes a latched event; 1 masks it.
// - Edge select picks which status transition sets the latch.
// - Reading an event-latch register clears its bits.
// - Reading a channel latch register clears that channel request bit only if its other latch register holds no enabled event.
// - Request pin drops only when every channel's events are acknowledged.
// - Eight events carry level status, latch, edge select and enable.
// - Eight pulse events carry only latch and enable bits.
// - Any write to the soft reset register resets chip within 1 us.
// - During reset: line drivers off; after it: flops cleared, registers at defaults.
// - Global writes affect both channels; local writes only their channel unless broadcast is on.
// - Second channel local registers sit 0x20 above the first.
// - Broadcast bit copies any local write to the other channel.
// - Global config and channel request field layouts as listed.
`timescale 1ns/1ns
`default_nettype none
module host_irq_unit
  import lineif_pkg::*;
(
  input  wire logic            i_sys_clk,
  input  wire logic            i_rst,
  input  wire logic            i_clk_en,
  input  wire logic [1:0]      i_host_bus_sel,
  input  wire logic            i_pbus_cs_n,
  input  wire logic            i_pbus_strb_n,
  input  wire logic            i_pbus_dir,
  input  wire logic [5:0]      i_pbus_addr,
  input  wire logic [7:0]      i_pbus_wdata,
  output logic      [7:0]      o_pbus_rdata,
  output logic                 o_pbus_rdata_oe,
  input  wire logic            i_serial_clk,
  input  wire logic            i_serial_cs_n,
  input  wire logic            i_serial_in_pin,
  output logic                 o_serial_out_pin,
  output logic                 o_serial_out_oe,
  input  wire logic [1:0][7:0] i_line_state,
  input  wire logic [1:0][7:0] i_event_pulse,
  output logic                 o_irq_pin,
  output logic                 o_irq_oe,
  output logic      [1:0]      o_monitor_select,
  output logic                 o_line_standard_select,
  output logic                 o_line_drivers_hiz
);
  import lineif_pkg::*;

  typedef struct packed {
    logic [1:0] bus_mode;
    logic       strap_done;
    logic [7:0] gcfg;
    logic [3:0] srst_cnt;
    logic       strb_q;
    logic       dir_q;
    logic [7:0] prdata;
    logic       irq_q;
  } main_s;

  localparam main_s MAIN_RST = '{gcfg: GCFG_RST, default: '0};

  main_s           s;
  main_s           next_s;
  logic            soft_rst;
  logic            ch_rst;
  logic            par_a;
  logic            par_b;
  logic            is_a;
  logic            is_b;
  logic            is_ser;
  logic            par_rd;
  logic            par_wr;
  logic            ser_rd;
  logic            ser_wr;
  logic [5:0]      ser_addr;
  logic [7:0]      ser_wdata;
  logic            acc_rd;
  logic            acc_wr;
  logic [5:0]      acc_addr;
  logic [7:0]      acc_wdata;
  logic [4:0]      acc_off;
  logic            acc_ch;
  logic            acc_local;
  logic [7:0]      rd_data;
  logic [1:0]      pend;
  logic [1:0]      wr_ch;
  logic [1:0]      rd_la;
  logic [1:0]      rd_lb;
  logic [1:0][7:0] la;
  logic [1:0][7:0] lb;
  logic [1:0][7:0] ena;
  logic [1:0][7:0] enb;
  logic [1:0][7:0] edg;
  logic [1:0][7:0] st;

  assign soft_rst = s.srst_cnt != 4'h0;
  assign ch_rst   = i_rst || soft_rst;
  assign is_a     = s.bus_mode == BUS_PAR_A;
  assign is_b     = s.bus_mode == BUS_PAR_B;
  assign is_ser   = s.bus_mode == BUS_SERIAL;
  assign par_a    = !i_pbus_cs_n && !i_pbus_strb_n;
  assign par_b    = !i_pbus_cs_n && !i_pbus_dir;
  // style A: one strobe, direction pin says read or write
  // style B: strobe is read, direction pin is write strobe
  assign par_rd = par_a && !s.strb_q && (is_b || (is_a && i_pbus_dir));
  assign par_wr = (is_a && par_a && !s.strb_q && !i_pbus_dir) ||
                  (is_b && par_b && !s.dir_q);

  host_serial_port u_serial (
    .i_sys_clk (i_sys_clk),
    .i_rst     (ch_rst),
    .i_clk_en  (i_clk_en),
    .i_sclk    (i_serial_clk),
    .i_cs_n    (i_serial_cs_n || !is_ser),
    .i_sdi     (i_serial_in_pin),
    .i_rdata   (rd_data),
    .o_rd_req  (ser_rd),
    .o_wr_req  (ser_wr),
    .o_addr    (ser_addr),
    .o_wdata   (ser_wdata),
    .o_sdo     (o_serial_out_pin),
    .o_sdo_oe  (o_serial_out_oe)
  );

  // serial port owns the registers only in serial mode
  assign acc_rd    = par_rd || (is_ser && ser_rd);
  assign acc_wr    = par_wr || (is_ser && ser_wr);
  assign acc_addr  = is_ser ? ser_addr : i_pbus_addr;
  assign acc_wdata = is_ser ? ser_wdata : i_pbus_wdata;
  assign acc_off   = acc_addr[4:0];
  assign acc_ch    = acc_addr[CH_SEL_BIT];
  assign acc_local = acc_off >= OFS_LOCAL_LO;

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      // local writes reach one channel unless broadcast is on
      assign wr_ch[c] = acc_wr && acc_local &&
                        (acc_ch == 1'(c) || s.gcfg[GC_BCAST]);
      assign rd_la[c] = acc_rd && acc_local && acc_ch == 1'(c) &&
                        acc_off == OFS_LATCH_A;
      assign rd_lb[c] = acc_rd && acc_local && acc_ch == 1'(c) &&
                        acc_off == OFS_LATCH_B;
      channel_events u_events (
        .i_sys_clk     (i_sys_clk),
        .i_rst         (ch_rst),
        .i_clk_en      (i_clk_en),
        .i_line_state  (i_line_state[c]),
        .i_event_pulse (i_event_pulse[c]),
        .i_wr          (wr_ch[c]),
        .i_off         (acc_off),
        .i_wdata       (acc_wdata),
        .i_rd_latch_a  (rd_la[c]),
        .i_rd_latch_b  (rd_lb[c]),
        .o_latch_a     (la[c]),
        .o_latch_b     (lb[c]),
        .o_en_a        (ena[c]),
        .o_en_b        (enb[c]),
        .o_edge        (edg[c]),
        .o_state       (st[c]),
        .o_pending     (pend[c])
      );
    end
  endgenerate

  always_comb begin
    rd_data = 8'h00;
    if (acc_local) begin
      unique case (acc_off)
        OFS_EN_A:    rd_data = ena[acc_ch];
        OFS_EN_B:    rd_data = enb[acc_ch];
        OFS_EDGE:    rd_data = edg[acc_ch];
        OFS_STATE_A: rd_data = st[acc_ch];
        OFS_LATCH_A: rd_data = la[acc_ch];
        OFS_LATCH_B: rd_data = lb[acc_ch];
        default:     rd_data = 8'h00;
      endcase
    end else begin
      unique case (acc_addr)
        ADDR_REV:   rd_data = REV_CODE;
        ADDR_GCFG:  rd_data = s.gcfg;
        // request bit follows pending, so it clears once latch reads leave no enabled event latched
        ADDR_CHREQ: rd_data = {6'h00, pend};
        default:    rd_data = 8'h00;
      endcase
    end
  end

  always_comb begin
    next_s = s;
    next_s.strb_q = par_a;
    next_s.dir_q = par_b;
    // one request for all events of both channels
    next_s.irq_q = (|pend) && !s.gcfg[GC_GDIS];
    if (!s.strap_done) begin
      next_s.bus_mode = i_host_bus_sel;
      next_s.strap_done = 1'b1;
    end
    if (par_rd) begin
      next_s.prdata = rd_data;
    end
    if (acc_wr && acc_addr == ADDR_GCFG) begin
      next_s.gcfg = acc_wdata & GCFG_MASK;
    end
    if (acc_wr && acc_addr == ADDR_SRST) begin
      next_s.srst_cnt = SRST_HOLD;
    end
    if (soft_rst) begin
      next_s = MAIN_RST;
      next_s.srst_cnt = 4'(s.srst_cnt - 4'h1);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s <= MAIN_RST;
    end else if (i_clk_en) begin
      s <= next_s;
    end
  end

  always_comb begin
    unique case (s.gcfg[GC_PIN_HI:GC_PIN_LO])
      PIN_OD_LOW: begin
        o_irq_pin = 1'b0;
        o_irq_oe = s.irq_q;
      end
      PIN_PP_HI: begin
        o_irq_pin = s.irq_q;
        o_irq_oe = 1'b1;
      end
      default: begin
        o_irq_pin = !s.irq_q;
        o_irq_oe = 1'b1;
      end
    endcase
  end

  assign o_pbus_rdata = s.prdata;
  assign o_pbus_rdata_oe = par_a && (is_b || (is_a && i_pbus_dir));
  assign o_monitor_select = s.gcfg[GC_MON_HI:GC_MON_LO];
  assign o_line_standard_select = s.gcfg[GC_STD];
  assign o_line_drivers_hiz = i_rst || soft_rst;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst || !i_clk_en);

  chk_par_read_data: assert property (
    is_a && par_rd |=> o_pbus_rdata == $past(rd_data))
    else $error("parallel read data wrong");
  chk_style_b_write: assert property (
    is_b && par_wr && i_pbus_addr == ADDR_GCFG && !soft_rst
    |=> s.gcfg == ($past(i_pbus_wdata) & GCFG_MASK))
    else $error("style b write lost");
  chk_serial_no_par: assert property (
    is_ser |-> !o_pbus_rdata_oe && !par_wr)
    else $error("parallel bus active in serial mode");
  chk_od_pin: assert property (
    s.gcfg[GC_PIN_LO] == 1'b0 && s.gcfg[GC_PIN_HI] == 1'b0
    |-> o_irq_pin == 1'b0 && o_irq_oe == s.irq_q)
    else $error("open drain pin misdriven");
  chk_pp_high: assert property (
    s.gcfg[GC_PIN_HI:GC_PIN_LO] == PIN_PP_HI
    |-> o_irq_oe && o_irq_pin == s.irq_q)
    else $error("active high pin misdriven");
  chk_gdis_quiet: assert property (
    s.gcfg[GC_GDIS] && $past(s.gcfg[GC_GDIS]) |-> !s.irq_q)
    else $error("request while globally disabled");
  chk_req_raise: assert property (
    (|pend) && !s.gcfg[GC_GDIS] && !soft_rst |=> s.irq_q)
    else $error("pending event not signalled");
  chk_srst_len: assert property (
    acc_wr && acc_addr == ADDR_SRST && !soft_rst
    |=> soft_rst [*8] ##1 soft_rst ##1 !soft_rst)
    else $error("soft reset length wrong");
  chk_bcast_copy: assert property (
    acc_wr && acc_local && acc_off == OFS_EDGE && s.gcfg[GC_BCAST]
    && !soft_rst |=> edg[0] == $past(acc_wdata) &&
    edg[1] == $past(acc_wdata))
    else $error("broadcast write not copied");
  chk_latch_clear: assert property (
    rd_la[0] && !soft_rst && i_line_state[0] == st[0]
    |=> la[0] == 8'h00)
    else $error("latch not cleared on read");

  cov_par_read: cover property (is_a && par_rd);
  cov_ser_write: cover property (is_ser && ser_wr);
  cov_irq: cover property (!s.irq_q ##1 s.irq_q);
  cov_srst: cover property (acc_wr && acc_addr == ADDR_SRST);
endmodule
`default_nettype wire

// file: verification/host_mcu_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_mcu_model (
  input  wire logic       i_sys_clk,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_sdo,
  input  wire logic       i_rdata_oe,
  input  wire logic       i_sdo_oe,
  output logic            o_cs_n,
  output logic            o_strb_n,
  output logic            o_dir,
  output logic      [5:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_sclk,
  output logic            o_scs_n,
  output logic            o_sdi
);
  initial begin
    o_cs_n = 1'b1;
    o_strb_n = 1'b1;
    o_dir = 1'b1;
    o_addr = 6'h15;
    o_wdata = 8'h5a;
    o_sclk = 1'b0;
    o_scs_n = 1'b1;
    o_sdi = 1'b1;
  end

  task automatic cycles(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  // style a: dir gives direction; style b: strb_n reads, dir writes
  task automatic par_xfer(input logic sty_b, input logic rd,
                          input logic [5:0] a, input logic [7:0] d,
                          output logic [7:0] q);
    cycles(1);
    o_addr = a;
    o_wdata = d;
    o_cs_n = 1'b0;
    o_strb_n = sty_b ? !rd : 1'b0;
    o_dir = rd;
    cycles(2);
    q = i_rdata_oe ? i_rdata : ~i_rdata;
    o_cs_n = 1'b1;
    o_strb_n = 1'b1;
    o_dir = 1'b1;
    o_addr = ~a;
    o_wdata = ~d;
    cycles(1);
  endtask

  // command byte lsb first, then data; sample before each rise
  task automatic ser_xfer(input logic rd, input logic [5:0] a,
                          input logic [7:0] d, output logic [7:0] q);
    logic [15:0] w;
    w = {d, 1'b0, rd, a};
    q = 8'h00;
    o_scs_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      o_sdi = w[i];
      cycles(3);
      if (i >= 8) begin
        q[i-8] = i_sdo_oe ? i_sdo : !i_sdo;
      end
      o_sclk = 1'b1;
      cycles(2);
      o_sclk = 1'b0;
    end
    cycles(2);
    o_scs_n = 1'b1;
    o_sdi = ~w[15];
    cycles(2);
  endtask
endmodule
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import lineif_pkg::*;
  logic            sys_clk, rst, clk_en, cs_n, strb_n, dir, sclk, scs_n;
  logic            serial_in_pin, serial_out_pin, irq_pin, irq_oe, std_sel, hiz, irq_line;
  logic            rd_oe, sdo_oe;
  logic [1:0]      strap, bus, mon_sel;
  logic [5:0]      addr;
  logic [7:0]      wdata, rdata;
  logic [1:0][7:0] line_state, event_pulse;
  int              mismatches, checks_done;

  assign irq_line = irq_oe ? irq_pin : 1'b1;

  always #50 sys_clk = ~sys_clk;

  host_irq_unit host_irq_unit_inst (
    .i_sys_clk             (sys_clk),
    .i_rst                 (rst),
    .i_clk_en              (clk_en),
    .i_host_bus_sel        (strap),
    .i_pbus_cs_n           (cs_n),
    .i_pbus_strb_n         (strb_n),
    .i_pbus_dir            (dir),
    .i_pbus_addr           (addr),
    .i_pbus_wdata          (wdata),
    .o_pbus_rdata          (rdata),
    .o_pbus_rdata_oe       (rd_oe),
    .i_serial_clk          (sclk),
    .i_serial_cs_n         (scs_n),
    .i_serial_in_pin       (serial_in_pin),
    .o_serial_out_pin      (serial_out_pin),
    .o_serial_out_oe       (sdo_oe),
    .i_line_state          (line_state),
    .i_event_pulse         (event_pulse),
    .o_irq_pin             (irq_pin),
    .o_irq_oe              (irq_oe),
    .o_monitor_select      (mon_sel),
    .o_line_standard_select(std_sel),
    .o_line_drivers_hiz    (hiz)
  );

  host_mcu_model host_mcu_model_inst (
    .i_sys_clk(sys_clk),
    .i_rdata  (rdata),
    .i_sdo    (serial_out_pin),
    .i_rdata_oe(rd_oe),
    .i_sdo_oe (sdo_oe),
    .o_cs_n   (cs_n),
    .o_strb_n (strb_n),
    .o_dir    (dir),
    .o_addr   (addr),
    .o_wdata  (wdata),
    .o_sclk   (sclk),
    .o_scs_n  (scs_n),
    .o_sdi    (serial_in_pin)
  );

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_irq(input string nm, input logic [1:0] e);
    checks_done++;
    if ({irq_oe, irq_line} !== e) begin
      mismatches++;
      $display("BAD %s expected %b seen %b", nm, e, {irq_oe, irq_line});
    end
  endtask

  // {drive enable, wire level with pull-up}
  function automatic logic [1:0] irq_exp(input logic [1:0] m,
                                         input logic a);
    if (m == PIN_OD_LOW) begin
      return {a, !a};
    end
    if (m == PIN_PP_HI) begin
      return {1'b1, a};
    end
    return {1'b1, !a};
  endfunction

  task automatic xfer(input logic r, input logic [5:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    if (bus == BUS_SERIAL) begin
      host_mcu_model_inst.ser_xfer(r, a, d, q);
    end else begin
      host_mcu_model_inst.par_xfer(bus == BUS_PAR_B, r, a, d, q);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b0, a, d, q);
  endtask

  task automatic rd(input string nm, input logic [5:0] a,
                    input logic [7:0] e);
    logic [7:0] q;
    xfer(1'b1, a, 8'h00, q);
    chk8(nm, e, q);
  endtask

  task automatic pulse(input int ch, input int b);
    event_pulse[ch][b] = 1'b1;
    tick(1);
    event_pulse = '0;
    tick(2);
  endtask

  task automatic timeout;
    mismatches++;
    $display("BAD wait expected done seen timeout");
    print_verdict();
  endtask

  task automatic t_defaults;
    rd("revision", ADDR_REV, REV_CODE);
    rd("config", ADDR_GCFG, GCFG_RST);
    rd("enable a", {1'b0, OFS_EN_A}, EN_RST);
    rd("edge sel", {1'b0, OFS_EDGE}, EDGE_RST);
    rd("unmapped", 6'h17, 8'h00);
    wr(ADDR_CHREQ, 8'hff);
    rd("request ro", ADDR_CHREQ, 8'h00);
    wr(ADDR_GCFG, 8'hff);
    rd("config all", ADDR_GCFG, GCFG_MASK);
    chk8("monitor", 8'h03, {6'h00, mon_sel});
    chk8("standard", 8'h01, {7'h00, std_sel});
    wr(ADDR_GCFG, 8'h00);
  endtask

  task automatic t_events;
    wr({1'b0, OFS_EN_A}, 8'hfe);
    line_state[0][0] = 1'b1;
    tick(3);
    rd("state a", {1'b0, OFS_STATE_A}, 8'h01);
    rd("request", ADDR_CHREQ, 8'h01);
    chk_irq("pin on", irq_exp(PIN_OD_LOW, 1'b1));
    rd("latch a", {1'b0, OFS_LATCH_A}, 8'h01);
    rd("request clr", ADDR_CHREQ, 8'h00);
    tick(2);
    chk_irq("pin off", irq_exp(PIN_OD_LOW, 1'b0));
    rd("latch a clr", {1'b0, OFS_LATCH_A}, 8'h00);
    wr({1'b0, OFS_EDGE}, 8'h01);
    line_state[0][0] = 1'b0;
    tick(3);
    rd("fall edge", {1'b0, OFS_LATCH_A}, 8'h01);
    line_state[0][0] = 1'b1;
    tick(3);
    rd("rise ignored", {1'b0, OFS_LATCH_A}, 8'h00);
    pulse(0, 4);
    rd("masked req", ADDR_CHREQ, 8'h00);
    rd("latch b", {1'b0, OFS_LATCH_B}, 8'h10);
  endtask

  task automatic t_two;
    wr({1'b0, OFS_EN_B}, 8'h00);
    wr({1'b1, OFS_EN_B}, 8'h00);
    event_pulse[1][1] = 1'b1;
    pulse(0, 1);
    rd("both req", ADDR_CHREQ, 8'h03);
    rd("ch1 latch", {1'b0, OFS_LATCH_B}, 8'h02);
    rd("ch2 left", ADDR_CHREQ, 8'h02);
    chk_irq("pin held", irq_exp(PIN_OD_LOW, 1'b1));
    rd("ch2 latch", {1'b1, OFS_LATCH_B}, 8'h02);
    tick(2);
    chk_irq("pin free", irq_exp(PIN_OD_LOW, 1'b0));
  endtask

  task automatic t_modes;
    pulse(0, 1);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_GCFG, 8'(m));
      tick(2);
      chk_irq("mode on", irq_exp(2'(m), 1'b1));
      wr(ADDR_GCFG, 8'(m + 4));
      tick(2);
      chk_irq("disabled", irq_exp(2'(m), 1'b0));
    end
    rd("ack", {1'b0, OFS_LATCH_B}, 8'h02);
    wr(ADDR_GCFG, 8'h00);
    clk_en = 1'b0;
    pulse(0, 1);
    clk_en = 1'b1;
    rd("frozen", ADDR_CHREQ, 8'h00);
  endtask

  task automatic t_bcast;
    wr({1'b1, OFS_EN_A}, 8'h5c);
    rd("ch1 kept", {1'b0, OFS_EN_A}, 8'hfe);
    rd("ch2 own", {1'b1, OFS_EN_A}, 8'h5c);
    wr(ADDR_GCFG, 8'h08);
    wr({1'b0, OFS_EDGE}, 8'ha5);
    rd("copy ch2", {1'b1, OFS_EDGE}, 8'ha5);
    rd("copy ch1", {1'b0, OFS_EDGE}, 8'ha5);
    wr(ADDR_GCFG, 8'h00);
  endtask

  task automatic t_srst(input logic [1:0] s);
    int n;
    n = 0;
    strap = s;
    wr(ADDR_SRST, 8'h3c);
    while (hiz !== 1'b1) begin
      tick(1);
      n++;
      if (n > 20) timeout();
    end
    while (hiz === 1'b1) begin
      tick(1);
      n++;
      if (n > 20) timeout();
    end
    chk8("reset time", 8'h01, {7'h00, n <= 10});
    bus = s;
    tick(3);
  endtask

  task automatic t_serial;
    rd("ser default", ADDR_GCFG, GCFG_RST);
    rd("ser enable", {1'b0, OFS_EN_A}, EN_RST);
    wr(ADDR_GCFG, 8'h90);
    rd("ser config", ADDR_GCFG, 8'h90);
    chk8("ser monitor", 8'h02, {6'h00, mon_sel});
    wr({1'b1, OFS_EDGE}, 8'h6b);
    rd("ser local", {1'b1, OFS_EDGE}, 8'h6b);
  endtask

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    clk_en = 1'b1;
    strap = BUS_PAR_A;
    bus = BUS_PAR_A;
    line_state = '0;
    event_pulse = '0;
    mismatches = 0;
    checks_done = 0;
    tick(12); // reset held well past its minimum
    chk8("drivers off", 8'h01, {7'h00, hiz});
    rst = 1'b0;
    tick(3);
    t_defaults();
    t_events();
    t_two();
    t_modes();
    t_bcast();
    t_srst(BUS_SERIAL);
    t_serial();
    t_srst(BUS_PAR_B);
    wr({1'b0, OFS_EN_B}, 8'hc3);
    rd("style b", {1'b0, OFS_EN_B}, 8'hc3);
    rd("style b rev", ADDR_REV, REV_CODE);
    wr(ADDR_GCFG, 8'h61);
    rd("style b cfg", ADDR_GCFG, 8'h41);
    print_verdict();
  end
endmodule
`default_nettype wire
